// ===== include/nfc_consts.vh
// opcodes, address layout and strobe timing counts for the flash host
`ifndef NFC_CONSTS_VH
`define NFC_CONSTS_VH
`define NFC_OP_READ_SETUP    8'h00
`define NFC_OP_READ_EXEC     8'h30
`define NFC_OP_READ_COPY     8'h35
`define NFC_OP_COL_OUT_SETUP 8'h05
`define NFC_OP_COL_OUT_EXEC  8'hE0
`define NFC_OP_ID            8'h90
`define NFC_OP_RESET         8'hFF
`define NFC_OP_PROG_SETUP    8'h80
`define NFC_OP_PROG_EXEC     8'h10
`define NFC_OP_CACHE_EXEC    8'h15
`define NFC_OP_COPY_SETUP    8'h85
`define NFC_OP_ERASE_SETUP   8'h60
`define NFC_OP_ERASE_EXEC    8'hD0
`define NFC_OP_STATUS        8'h70
`define NFC_PAGES            17'h10000
`define NFC_PAGE_BYTES       12'h840
`define NFC_SPARE_FIRST      12'h800
`define NFC_BLOCKS           11'h400
`define NFC_COL_BITS         12
`define NFC_ROW_BITS         16
`define NFC_FIFO_DEPTH       32
`define NFC_STROBE_NS        30
`define NFC_CLK_NS           10
`define NFC_STROBE_CYC       ((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// ===== logic/nfc_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module nfc_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
)
(
    input  wire             core_clk_i,
    input  wire             sys_rst_i,
    input  wire             clk_en_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o & clk_en_i;
    assign pop  = out_valid_o & out_ready_i & clk_en_i;

    always @(posedge core_clk_i)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_i;
    end

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push & ~pop)
                count_reg <= count_reg + 1'b1;
            else if (pop & ~push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// ===== logic/nfc_host.v
// nand flash host: sequences opcode, address and data strobes
`timescale 1ns/1ps
`include "nfc_consts.vh"
// Behaviour
// - Host drives I/O with chip select and write strobe low.
// - Command latch marks opcodes, address latch marks address bytes.
// - Address bytes travel on the low eight I/O lines only.
// - Reset, status and identifier reads use one opcode cycle.
// - Read, program and erase use setup then execute opcode, except lone 85h.
// - Read/program send two column then two row address cycles; column moves send only the two column cycles.
// - Erase sends 60h, two row cycles, then D0h.
// - Reads: 00h-30h, 00h-35h copy read, 05h-E0h column move.
// - Programs: 80h-10h, 80h-15h cache, 85h-10h copy, lone 85h.
// - While busy, host issues only reset or status opcodes.
// - Host never sends an opcode outside the defined set.
module nfc_host
(
    input  wire        core_clk_i,
    input  wire        sys_rst_i,
    input  wire        clk_en_i,
    input  wire        cmd_valid_i,
    output wire        cmd_ready_o,
    input  wire [3:0]  cmd_op_i,
    input  wire [15:0] cmd_row_i,
    input  wire [11:0] cmd_col_i,
    input  wire [11:0] cmd_len_i,
    input  wire [7:0]  wr_data_i,
    input  wire        wr_valid_i,
    output wire        wr_ready_o,
    output wire [7:0]  rd_data_o,
    output wire        rd_valid_o,
    input  wire        rd_ready_i,
    output reg         done_o,
    output reg         busy_o,
    output reg         chip_sel_n_o,
    output reg         cmd_latch_o,
    output reg         addr_latch_o,
    output reg         write_strobe_n_o,
    output reg         output_strobe_n_o,
    output reg  [7:0]  io_o,
    output reg         io_oe_o,
    input  wire [7:0]  io_i,
    input  wire        ready_busy_n_i
);
    // host operation codes
    localparam OP_READ  = 4'h0;
    localparam OP_RCOPY = 4'h1;
    localparam OP_COLRD = 4'h2;
    localparam OP_ID    = 4'h3;
    localparam OP_RESET = 4'h4;
    localparam OP_PROG  = 4'h5;
    localparam OP_CACHE = 4'h6;
    localparam OP_COPYP = 4'h7;
    localparam OP_ERASE = 4'h8;
    localparam OP_STAT  = 4'h9;
    localparam OP_COLWR = 4'hA;
    localparam OP_AUTO  = 4'hB;

    localparam S_IDLE = 3'h0;
    localparam S_CMD1 = 3'h1;
    localparam S_ADDR = 3'h2;
    localparam S_WDAT = 3'h3;
    localparam S_CMD2 = 3'h4;
    localparam S_WAIT = 3'h5;
    localparam S_RDAT = 3'h6;

    reg [2:0]  state_reg;
    reg [3:0]  op_reg;
    reg [15:0] row_reg;
    reg [11:0] col_reg;
    reg [11:0] cnt_reg;
    reg [1:0]  acnt_reg;
    reg [1:0]  ph_reg;
    reg [1:0]  tick_reg;
    reg        push_reg;
    reg [7:0]  push_data_reg;

    wire [7:0] wf_data;
    wire       wf_valid;
    wire       wf_pop;
    wire       rf_ready;
    localparam TICK_END  = `NFC_STROBE_CYC - 1;
    wire       tick_done = (tick_reg == TICK_END[1:0]);

    // setup opcode; illegal codes send the status opcode 70h, then four address cycles and 00h, with no status read
    function [7:0] first_op;
        input [3:0] op;
        begin
            case (op)
                OP_READ, OP_RCOPY: first_op = `NFC_OP_READ_SETUP;
                OP_COLRD:          first_op = `NFC_OP_COL_OUT_SETUP;
                OP_ID:             first_op = `NFC_OP_ID;
                OP_RESET:          first_op = `NFC_OP_RESET;
                OP_PROG, OP_CACHE: first_op = `NFC_OP_PROG_SETUP;
                OP_COPYP, OP_COLWR: first_op = `NFC_OP_COPY_SETUP;
                OP_ERASE:          first_op = `NFC_OP_ERASE_SETUP;
                default:           first_op = `NFC_OP_STATUS;
            endcase
        end
    endfunction

    // execute opcode; zero for one-cycle commands, but illegal codes still send it as 00h
    function [7:0] second_op;
        input [3:0] op;
        begin
            case (op)
                OP_READ:  second_op = `NFC_OP_READ_EXEC;
                OP_RCOPY: second_op = `NFC_OP_READ_COPY;
                OP_COLRD: second_op = `NFC_OP_COL_OUT_EXEC;
                OP_PROG:  second_op = `NFC_OP_PROG_EXEC;
                OP_COPYP: second_op = `NFC_OP_PROG_EXEC;
                OP_CACHE: second_op = `NFC_OP_CACHE_EXEC;
                OP_ERASE: second_op = `NFC_OP_ERASE_EXEC;
                default:  second_op = 8'h00;
            endcase
        end
    endfunction

    // address cycles: column moves 2, erase 2 rows, id 1, reset/status/auto 0, others 4
    function [2:0] addr_cycles;
        input [3:0] op;
        begin
            case (op)
                OP_RESET, OP_STAT, OP_AUTO: addr_cycles = 3'h0;
                OP_ID:              addr_cycles = 3'h1;
                OP_COLRD, OP_COLWR: addr_cycles = 3'h2;
                OP_ERASE:           addr_cycles = 3'h2;
                default:            addr_cycles = 3'h4;
            endcase
        end
    endfunction

    wire is_wr = (op_reg == OP_PROG) | (op_reg == OP_CACHE) |
                 (op_reg == OP_COLWR) | (op_reg == OP_COPYP);

    // busy device takes only reset and status
    assign cmd_ready_o = (state_reg == S_IDLE) & (ready_busy_n_i |
        (cmd_op_i == OP_RESET) | (cmd_op_i == OP_STAT));
    assign wf_pop = (state_reg == S_WDAT) & (ph_reg == 2'h0) & wf_valid &
                    clk_en_i;

    nfc_fifo
    #(
        .WIDTH (8),
        .DEPTH (`NFC_FIFO_DEPTH),
        .AW    (5)
    )
    u_wr_fifo
    (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i),
        .clk_en_i    (clk_en_i),
        .in_data_i   (wr_data_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .out_data_o  (wf_data),
        .out_valid_o (wf_valid),
        .out_ready_i (wf_pop)
    );

    nfc_fifo
    #(
        .WIDTH (8),
        .DEPTH (`NFC_FIFO_DEPTH),
        .AW    (5)
    )
    u_rd_fifo
    (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i),
        .clk_en_i    (clk_en_i),
        .in_data_i   (push_data_reg),
        .in_valid_i  (push_reg),
        .in_ready_o  (rf_ready),
        .out_data_o  (rd_data_o),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i)
    );

    // --------------------------------------------------------------
    // strobe sequencer: ph 0 drives strobe low, ph 1 low phase, ph 2 high phase
    // --------------------------------------------------------------
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg         <= S_IDLE;
            op_reg            <= 4'h0;
            row_reg           <= 16'h0000;
            col_reg           <= 12'h000;
            cnt_reg           <= 12'h000;
            acnt_reg          <= 2'h0;
            ph_reg            <= 2'h0;
            tick_reg          <= 2'h0;
            push_reg          <= 1'b0;
            push_data_reg     <= 8'h00;
            done_o            <= 1'b0;
            busy_o            <= 1'b0;
            chip_sel_n_o      <= 1'b1;
            cmd_latch_o       <= 1'b0;
            addr_latch_o      <= 1'b0;
            write_strobe_n_o  <= 1'b1;
            output_strobe_n_o <= 1'b1;
            io_o              <= 8'h00;
            io_oe_o           <= 1'b0;
        end
        else if (clk_en_i)
        begin
            done_o   <= 1'b0;
            push_reg <= 1'b0;
            if (state_reg != S_IDLE && !tick_done)
                tick_reg <= tick_reg + 2'h1;
            case (state_reg)
                S_IDLE:
                begin
                    busy_o <= 1'b0;
                    if (cmd_valid_i && cmd_ready_o)
                    begin
                        op_reg       <= cmd_op_i;
                        row_reg      <= cmd_row_i;
                        col_reg      <= cmd_col_i;
                        cnt_reg      <= cmd_len_i;
                        busy_o       <= 1'b1;
                        chip_sel_n_o <= 1'b0;
                        ph_reg       <= 2'h0;
                        tick_reg     <= 2'h0;
                        acnt_reg     <= 2'h0;
                        // auto-read page: straight to serial output
                        state_reg    <= (cmd_op_i == OP_AUTO) ? S_RDAT :
                                        S_CMD1;
                    end
                end
                S_CMD1, S_CMD2:
                begin
                    if (ph_reg == 2'h0)
                    begin
                        cmd_latch_o      <= 1'b1;
                        write_strobe_n_o <= 1'b0;
                        io_oe_o          <= 1'b1;
                        io_o <= (state_reg == S_CMD1) ? first_op(op_reg) :
                                second_op(op_reg);
                        ph_reg   <= 2'h1;
                        tick_reg <= 2'h0;
                    end
                    else if (ph_reg == 2'h1 && tick_done)
                    begin
                        write_strobe_n_o <= 1'b1;
                        ph_reg   <= 2'h2;
                        tick_reg <= 2'h0;
                    end
                    else if (ph_reg == 2'h2 && tick_done)
                    begin
                        cmd_latch_o <= 1'b0;
                        io_oe_o     <= 1'b0;
                        ph_reg      <= 2'h0;
                        tick_reg    <= 2'h0;
                        if (state_reg == S_CMD2)
                            state_reg <= S_WAIT;
                        else if (addr_cycles(op_reg) != 3'h0)
                            state_reg <= S_ADDR;
                        else if (op_reg == OP_STAT)
                            state_reg <= S_RDAT;
                        else
                            state_reg <= S_WAIT;
                    end
                end
                S_ADDR:
                begin
                    if (ph_reg == 2'h0)
                    begin
                        addr_latch_o     <= 1'b1;
                        write_strobe_n_o <= 1'b0;
                        io_oe_o          <= 1'b1;
                        // erase sends only row bytes
                        case ((op_reg == OP_ERASE) ? acnt_reg + 2'h2 :
                              acnt_reg)
                            2'h0:    io_o <= col_reg[7:0];
                            2'h1:    io_o <= {4'h0, col_reg[11:8]};
                            2'h2:    io_o <= row_reg[7:0];
                            default: io_o <= row_reg[15:8];
                        endcase
                        ph_reg   <= 2'h1;
                        tick_reg <= 2'h0;
                    end
                    else if (ph_reg == 2'h1 && tick_done)
                    begin
                        write_strobe_n_o <= 1'b1;
                        ph_reg   <= 2'h2;
                        tick_reg <= 2'h0;
                    end
                    else if (ph_reg == 2'h2 && tick_done)
                    begin
                        addr_latch_o <= 1'b0;
                        io_oe_o      <= 1'b0;
                        ph_reg       <= 2'h0;
                        tick_reg     <= 2'h0;
                        acnt_reg     <= acnt_reg + 2'h1;
                        if ({1'b0, acnt_reg} == addr_cycles(op_reg) - 3'h1)
                        begin
                            if (is_wr)
                                state_reg <= (cnt_reg == 12'h000) ?
                                    ((op_reg == OP_COLWR) ? S_WAIT : S_CMD2)
                                    : S_WDAT;
                            else if (op_reg == OP_COLRD ||
                                     op_reg == OP_ID)
                                state_reg <= (op_reg == OP_ID) ? S_RDAT :
                                             S_CMD2;
                            else
                                state_reg <= S_CMD2;
                        end
                    end
                end
                S_WDAT:
                begin
                    if (ph_reg == 2'h0 && wf_valid)
                    begin
                        write_strobe_n_o <= 1'b0;
                        io_oe_o          <= 1'b1;
                        io_o             <= wf_data;
                        ph_reg   <= 2'h1;
                        tick_reg <= 2'h0;
                    end
                    else if (ph_reg == 2'h1 && tick_done)
                    begin
                        write_strobe_n_o <= 1'b1;
                        ph_reg   <= 2'h2;
                        tick_reg <= 2'h0;
                        cnt_reg  <= cnt_reg - 12'h001;
                    end
                    else if (ph_reg == 2'h2 && tick_done)
                    begin
                        io_oe_o  <= 1'b0;
                        ph_reg   <= 2'h0;
                        tick_reg <= 2'h0;
                        if (cnt_reg == 12'h000)
                            state_reg <= (op_reg == OP_COLWR) ? S_WAIT :
                                         S_CMD2;
                    end
                end
                S_WAIT:
                begin
                    // wait out ready/busy after strobe delay
                    if (tick_done && ready_busy_n_i)
                    begin
                        tick_reg <= 2'h0;
                        if (op_reg == OP_READ || op_reg == OP_COLRD)
                            state_reg <= S_RDAT;
                        else
                        begin
                            chip_sel_n_o <= 1'b1;
                            done_o       <= 1'b1;
                            state_reg    <= S_IDLE;
                        end
                    end
                end
                S_RDAT:
                begin
                    if (ph_reg == 2'h0 && rf_ready && cnt_reg != 12'h000)
                    begin
                        output_strobe_n_o <= 1'b0;
                        ph_reg   <= 2'h1;
                        tick_reg <= 2'h0;
                    end
                    else if (ph_reg == 2'h0 && cnt_reg == 12'h000)
                    begin
                        chip_sel_n_o <= 1'b1;
                        done_o       <= 1'b1;
                        state_reg    <= S_IDLE;
                    end
                    else if (ph_reg == 2'h1 && tick_done)
                    begin
                        output_strobe_n_o <= 1'b1;
                        push_reg      <= 1'b1;
                        push_data_reg <= io_i;
                        cnt_reg       <= cnt_reg - 12'h001;
                        ph_reg        <= 2'h2;
                        tick_reg      <= 2'h0;
                    end
                    else if (ph_reg == 2'h2 && tick_done)
                    begin
                        ph_reg   <= 2'h0;
                        tick_reg <= 2'h0;
                    end
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ===== tb/nfc_flash_model.sv
// behavioural flash device answering the host strobes
`timescale 1ns/1ps
module nfc_flash_model
(
    input  wire       chip_sel_n_i,
    input  wire       cmd_latch_i,
    input  wire       addr_latch_i,
    input  wire       write_strobe_n_i,
    input  wire       output_strobe_n_i,
    input  wire [7:0] bus_i,
    input  wire       hold_busy_i,
    input  int        busy_ns_i,
    output wire [7:0] bus_o,
    output wire       ready_busy_n_o
);
    logic [7:0]  op_q[$];
    logic [7:0]  adr_q[$];
    logic [7:0]  mem[int];
    logic [7:0]  dout    = 8'h00;
    logic [15:0] row     = 16'h0000;
    logic [11:0] col     = 12'h000;
    logic        busy    = 1'b0;
    int          bad_cnt = 0;
    assign ready_busy_n_o = !(busy || hold_busy_i);
    // released bus shows the inverse so stale data never passes
    assign bus_o = output_strobe_n_i ? ~dout : dout;
    always @(posedge write_strobe_n_i)
    begin
        if (!chip_sel_n_i && cmd_latch_i)
        begin
            op_q.push_back(bus_i);
            if (!ready_busy_n_o && !(bus_i inside {8'hFF, 8'h70}))
                bad_cnt++;
            if (!(bus_i inside {8'h00, 8'h30, 8'h35, 8'h05, 8'hE0, 8'h90,
                8'hFF, 8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0, 8'h70}))
                bad_cnt++;
            if (bus_i inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0})
            begin
                busy = 1'b1;
                busy <= #(busy_ns_i) 1'b0;
            end
        end
        else if (!chip_sel_n_i && addr_latch_i)
        begin
            case (adr_q.size())
                0: col[7:0] = bus_i;
                1: col[11:8] = bus_i[3:0];
                2: row[7:0] = bus_i;
                3: row[15:8] = bus_i;
                default: ;
            endcase
            adr_q.push_back(bus_i);
        end
        else if (!chip_sel_n_i)
        begin
            mem[{row, col}] = bus_i;
            col++;
        end
    end
    always @(negedge output_strobe_n_i)
        if (!chip_sel_n_i)
        begin
            dout = mem.exists({row, col}) ? mem[{row, col}] :
                   row[7:0] ^ col[7:0];
            col++;
        end
endmodule

// ===== tb/nfc_host_assertions.sv
// concurrent checks on the flash host pins and request handshake
`timescale 1ns/1ps
module nfc_host_checker
(
    input wire       core_clk_i,
    input wire       sys_rst_i,
    input wire       cmd_valid_i,
    input wire       cmd_ready_o,
    input wire [3:0] cmd_op_i,
    input wire       chip_sel_n_o,
    input wire       cmd_latch_o,
    input wire       addr_latch_o,
    input wire       write_strobe_n_o,
    input wire       output_strobe_n_o,
    input wire [7:0] io_o,
    input wire       io_oe_o,
    input wire       ready_busy_n_i
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_we_under_cs: assert property (
        !write_strobe_n_o |-> !chip_sel_n_o && io_oe_o)
        else $error("write strobe without select or drive");
    a_we_hold_bus: assert property (
        !write_strobe_n_o |=>
        $stable({io_o, cmd_latch_o, addr_latch_o, chip_sel_n_o}))
        else $error("bus moved before write strobe rose");
    a_we_width: assert property (
        $fell(write_strobe_n_o) |->
        !write_strobe_n_o [*3] ##1 write_strobe_n_o)
        else $error("write strobe width wrong");
    a_out_strobe_width: assert property (
        $fell(output_strobe_n_o) |->
        !output_strobe_n_o [*3] ##1 output_strobe_n_o)
        else $error("output strobe width wrong");
    a_latch_excl: assert property (
        !(cmd_latch_o && addr_latch_o))
        else $error("both latches high");
    a_opcode_set: assert property (
        cmd_latch_o && !write_strobe_n_o |-> io_o inside {8'h00, 8'h30,
        8'h35, 8'h05, 8'hE0, 8'h90, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h85,
        8'h60, 8'hD0, 8'h70})
        else $error("undefined opcode sent");
    a_busy_refuse: assert property (
        !ready_busy_n_i && cmd_op_i <= 4'hB && cmd_op_i != 4'h4 &&
        cmd_op_i != 4'h9 |-> !cmd_ready_o)
        else $error("request taken while device busy");
    a_read_quiet: assert property (
        !output_strobe_n_o |->
        !io_oe_o && !chip_sel_n_o && write_strobe_n_o)
        else $error("read strobe with host driving");
    c_program: cover property (cmd_latch_o && io_o == 8'h80);
    c_read: cover property ($fell(output_strobe_n_o));
    c_refused: cover property (cmd_valid_i && !cmd_ready_o);
endmodule
bind nfc_host nfc_host_checker CHK (.core_clk_i, .sys_rst_i, .cmd_valid_i,
    .cmd_ready_o, .cmd_op_i, .chip_sel_n_o, .cmd_latch_o, .addr_latch_o,
    .write_strobe_n_o, .output_strobe_n_o, .io_o, .io_oe_o,
    .ready_busy_n_i);

// ===== tb/tb_top.sv
// bench driving the flash host against a behavioural device
`timescale 1ns/1ps
module tb_top;
    logic        core_clk_i  = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic        clk_en_i    = 1'b1;
    logic        cmd_valid_i = 1'b0;
    logic [3:0]  cmd_op_i    = 4'h0;
    logic [15:0] cmd_row_i   = 16'h0000;
    logic [11:0] cmd_col_i   = 12'h000;
    logic [11:0] cmd_len_i   = 12'h000;
    logic [7:0]  wr_data_i   = 8'h00;
    logic        wr_valid_i  = 1'b0;
    logic        rd_ready_i  = 1'b0;
    logic        hold_busy   = 1'b0;
    int          busy_ns     = 100;
    int          error_cnt   = 0;
    int          check_count = 0;
    logic [7:0]  rx_q[$];
    wire  [7:0]  rd_data_o, io_o, dev_io, bus;
    wire         cmd_ready_o, wr_ready_o, rd_valid_o, done_o, busy_o;
    wire         chip_sel_n_o, cmd_latch_o, addr_latch_o, io_oe_o;
    wire         write_strobe_n_o, output_strobe_n_o, ready_busy_n;
    assign bus = io_oe_o ? io_o : dev_io;
    nfc_host DUT (.core_clk_i, .sys_rst_i, .clk_en_i, .cmd_valid_i,
        .cmd_ready_o, .cmd_op_i, .cmd_row_i, .cmd_col_i, .cmd_len_i,
        .wr_data_i, .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o,
        .rd_ready_i, .done_o, .busy_o, .chip_sel_n_o, .cmd_latch_o,
        .addr_latch_o, .write_strobe_n_o, .output_strobe_n_o, .io_o,
        .io_oe_o, .io_i(bus), .ready_busy_n_i(ready_busy_n));
    nfc_flash_model FLASH (.chip_sel_n_i(chip_sel_n_o),
        .cmd_latch_i(cmd_latch_o), .addr_latch_i(addr_latch_o),
        .write_strobe_n_i(write_strobe_n_o),
        .output_strobe_n_i(output_strobe_n_o), .bus_i(bus),
        .hold_busy_i(hold_busy), .busy_ns_i(busy_ns), .bus_o(dev_io),
        .ready_busy_n_o(ready_busy_n));
    initial forever #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
        if (rd_valid_o && rd_ready_i)
            rx_q.push_back(rd_data_o);
    task automatic check_eq(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic limit(input int n);
        if (n >= 20000)
        begin
            error_cnt++;
            complete_run();
        end
    endtask
    // size in the top byte, last five bytes below
    function automatic logic [47:0] pk(input int sel);
        logic [7:0]  q[$];
        logic [47:0] r;
        r = 48'h0;
        if (sel == 0)
            q = FLASH.op_q;
        else if (sel == 1)
            q = FLASH.adr_q;
        else
            q = rx_q;
        foreach (q[i])
            r = {r[39:0], q[i]};
        r[47:40] = 8'(q.size());
        return r;
    endfunction
    task automatic run_cmd(input logic [3:0] op, input logic [15:0] row,
        input logic [11:0] col, input logic [11:0] len, input int stall,
        input int frz);
        int n;
        FLASH.op_q.delete();
        FLASH.adr_q.delete();
        rx_q.delete();
        {cmd_op_i, cmd_row_i, cmd_col_i, cmd_len_i} = {op, row, col, len};
        clk_en_i = (frz == 0);
        cmd_valid_i = 1'b1;
        tick(frz);
        clk_en_i = 1'b1;
        if (frz > 0)
            check_eq({busy_o, 8'(FLASH.op_q.size())}, 9'h000);
        for (n = 0; cmd_ready_o !== 1'b1 && n < 20000; n++)
            tick(1);
        limit(n);
        tick(1);
        cmd_valid_i = 1'b0;
        for (n = 0; done_o !== 1'b1 && n < 20000; n++)
        begin
            rd_ready_i = (n >= stall);
            tick(1);
        end
        limit(n);
        rd_ready_i = 1'b1;
        for (n = 0; n < 40 && (n < 4 || rd_valid_o === 1'b1); n++)
            tick(1);
        rd_ready_i = 1'b0;
    endtask
    task automatic push_bytes(input logic [7:0] first, input int cnt,
        output int taken);
        taken = 0;
        for (int i = 0; i < cnt; i++)
        begin
            wr_data_i = first + taken[7:0];
            wr_valid_i = 1'b1;
            if (wr_ready_o === 1'b1)
                taken++;
            tick(1);
        end
        wr_valid_i = 1'b0;
    endtask
    task automatic s_auto_read();
        run_cmd(4'hB, 16'h0000, 12'h000, 12'h004, 0, 0);
        check_eq(pk(0), 48'h0);
        check_eq(pk(2), 48'h040000010203);
    endtask
    task automatic s_prog_read();
        int t;
        busy_ns = 3000;
        push_bytes(8'hC3, 4, t);
        run_cmd(4'h5, 16'h1234, 12'h830, 12'h004, 0, 0);
        check_eq(pk(0), 48'h020000008010);
        check_eq(pk(1), 48'h040030083412);
        run_cmd(4'h0, 16'h1234, 12'h830, 12'h004, 0, 0);
        check_eq(pk(0), 48'h020000000030);
        check_eq(pk(2), 48'h0400C3C4C5C6);
        busy_ns = 100;
    endtask
    task automatic s_table();
        logic [3:0]  op[9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8,
            4'h9, 4'hA};
        logic [47:0] eo[9] = '{48'h020000000035, 48'h0200000005E0,
            48'h010000000090, 48'h0100000000FF, 48'h020000008015,
            48'h020000008510, 48'h0200000060D0, 48'h010000000070,
            48'h010000000085};
        logic [47:0] ea[9] = '{48'h04001000A502, 48'h020000001000,
            48'h010000000010, 48'h0, 48'h04001000A502, 48'h04001000A502,
            48'h02000000A502, 48'h0, 48'h020000001000};
        foreach (op[i])
        begin
            run_cmd(op[i], 16'h02A5, 12'h010, 12'h000, 0, i == 7 ? 4 : 0);
            check_eq(pk(0), eo[i]);
            check_eq(pk(1), ea[i]);
        end
    endtask
    task automatic s_busy();
        hold_busy = 1'b1;
        cmd_op_i = 4'h0;
        tick(2);
        check_eq(cmd_ready_o, 1'b0);
        run_cmd(4'h9, 16'h0000, 12'h000, 12'h000, 0, 0);
        check_eq(pk(0), 48'h010000000070);
        hold_busy = 1'b0;
        check_eq(FLASH.bad_cnt, 0);
    endtask
    task automatic s_fifo();
        int t;
        push_bytes(8'h10, 34, t);
        check_eq({t[7:0], wr_ready_o}, {8'd32, 1'b0});
        run_cmd(4'h5, 16'h0040, 12'h000, 12'h020, 0, 0);
        check_eq(wr_ready_o, 1'b1);
        run_cmd(4'h0, 16'h0040, 12'h000, 12'h028, 300, 0);
        check_eq(pk(2), 48'h286364656667);
        check_eq(rx_q[31], 8'h2F);
    endtask
    initial
    begin
        tick(6);
        sys_rst_i = 1'b0;
        tick(1);
        s_auto_read();
        s_prog_read();
        s_table();
        s_busy();
        s_fifo();
        complete_run();
    end
endmodule
